// ---- cfpr_pkg.sv ----
// cfpr_pkg: shared constants for the channel filter profile register bank
// assumes a byte-wide register map reached as 32-bit wishbone words
package cfpr_pkg;
   localparam int CFPR_NCH = 4;
   localparam int CFPR_REG_W = 8;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [7:0] CFPR_IDX_PROF_A = 8'h01;
   localparam logic [7:0] CFPR_IDX_PROF_B = 8'h02;
   localparam logic [7:0] CFPR_IDX_MAP = 8'h03;
   localparam logic [7:0] CFPR_IDX_STATUS = 8'h10;
   localparam logic [7:0] CFPR_RST_PROF_A = 8'h0D;
   localparam logic [7:0] CFPR_RST_PROF_B = 8'h0D;
   localparam logic [7:0] CFPR_RST_MAP = 8'h00;
   localparam int CFPR_FILT_BIT = 3;
   localparam int CFPR_DEC_LSB = 0;
   localparam int CFPR_DEC_W = 3;
   localparam int CFPR_MAP_CH0_SEL = 0;
   localparam int CFPR_MAP_CH1_SEL = 1;
   localparam int CFPR_MAP_CH2_EN = 2;
   localparam int CFPR_MAP_CH3_EN = 3;
   localparam int CFPR_MAP_CH2_SEL = 4;
   localparam int CFPR_MAP_CH3_SEL = 5;
   localparam logic [7:0] CFPR_MAP_MASK = 8'h3F;
   localparam logic [7:0] CFPR_PROF_MASK = 8'h0F;
   localparam int CFPR_RES_W = 24;
   localparam int CFPR_PHASE_W = 5;
   // shortest output period: one data-ready per 32 modulator samples, longest 1024
   localparam int CFPR_DEC_MIN = 32;
   localparam int CFPR_DEC_MAX = 1024;

   typedef enum logic [1:0] {
      CFPR_ST_IDLE = 2'b00,
      CFPR_ST_ACK = 2'b01
   } cfpr_bus_e;

   // decimation code to log2 of the ratio relative to 32; codes 5..7 all give 1024
   function automatic logic [2:0] cfpr_dec_log(input logic [2:0] code);
      cfpr_dec_log = (code > 3'h5) ? 3'h5 : code;
   endfunction
endpackage

// ---- cfpr_wb_slave.sv ----
// cfpr_wb_slave: classic wishbone slave handshake, one wait state per access
// assumes a single-master classic bus on ref_clk
module cfpr_wb_slave
   import cfpr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic access_o
);
   cfpr_bus_e state_q;
   // ack is held off for one cycle so back-to-back strobes never double-fire
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= CFPR_ST_IDLE;
      end else begin
         case (state_q)
            CFPR_ST_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  state_q <= CFPR_ST_ACK;
               end
            end
            CFPR_ST_ACK: begin
               state_q <= CFPR_ST_IDLE;
            end
            default: begin
               state_q <= CFPR_ST_IDLE;
            end
         endcase
      end
   end
   assign wb_ack_o = (state_q == CFPR_ST_ACK);
   assign access_o = (state_q == CFPR_ST_IDLE) && wb_cyc_i && wb_stb_i;
endmodule

// ---- cfpr_pacer.sv ----
// cfpr_pacer: paces data-ready at the fastest profile rate, flags slower channels
// assumes mod_tick_i is one pulse per modulator output sample from the same clock
module cfpr_pacer
   import cfpr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic mod_tick_i,
   input wire logic [2:0] dec_log_a,
   input wire logic [2:0] dec_log_b,
   output logic [9:0] phase_o,
   output logic drdy_o,
   output logic fresh_a_o,
   output logic fresh_b_o
);
   logic [9:0] phase_q;
   logic [2:0] fast_log;
   logic [9:0] mask_fast;
   logic [9:0] mask_a;
   logic [9:0] mask_b;

   function automatic logic [9:0] cfpr_period_mask(input logic [2:0] lg);
      cfpr_period_mask = 10'((32'd32 << lg) - 32'd1);
   endfunction

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         phase_q <= 10'h000;
      end else if (mod_tick_i) begin
         phase_q <= phase_q + 10'h001;
      end
   end

   always_comb begin
      fast_log = (dec_log_a < dec_log_b) ? dec_log_a : dec_log_b;
      mask_fast = cfpr_period_mask(fast_log);
      mask_a = cfpr_period_mask(dec_log_a);
      mask_b = cfpr_period_mask(dec_log_b);
   end

   // data-ready when the fastest period wraps
   assign drdy_o = mod_tick_i && ((phase_q & mask_fast) == mask_fast);
   // a profile's result is fresh only where its own, slower period wraps
   assign fresh_a_o = drdy_o && ((phase_q & mask_a) == mask_a);
   assign fresh_b_o = drdy_o && ((phase_q & mask_b) == mask_b);
   assign phase_o = phase_q;
endmodule

// ---- cfpr_regs.sv ----
// cfpr_regs: two filter profiles, channel-to-profile map and output pacing
// assumes the converter core delivers one raw result per channel on each
// data-ready and that software reaches the registers over classic wishbone
//
// Contract
// - two independent profiles, each filter type and decimation, any channel may use either
// - data-ready pulses at the fastest selected decimation rate; code paces at the faster of both profiles even when no channel maps to it
// - slower channel gets a fresh result only at its own rate
// - between valid results slower channel reads zeros with repeated-data flag set
// - profile A at 0x01, reset 0x0D, bit 3 selects wideband or sinc5
// - profile A bits 2:0 decode 32..512, codes 101-111 give 1024
// - profile B at 0x02, reset 0x0D, bit 3 same filter meaning
// - profile B decimation uses profile A encoding
// - map register 0x03, reset 0x00, bit per channel, 0 is A, 1 is B
// - channel 3 select at bit 5, its enable at bit 3
//
// Register access over Wishbone was left to the implementer.
module cfpr_regs
   import cfpr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic mod_tick_i,
   input wire logic [CFPR_NCH*CFPR_RES_W-1:0] raw_data_i,
   output logic [CFPR_NCH*CFPR_RES_W-1:0] out_data_o,
   output logic [CFPR_NCH-1:0] out_repeat_o,
   output logic [CFPR_NCH-1:0] ch_filter_o,
   output logic [CFPR_NCH*CFPR_DEC_W-1:0] ch_dec_o,
   output logic drdy_o
);
   logic [7:0] prof_a_q;
   logic [7:0] prof_b_q;
   logic [7:0] map_q;
   logic [7:0] status_q;
   logic [31:0] rdata_q;
   logic access;
   logic wr_en;
   logic [7:0] idx;
   logic addr_ok;
   logic [7:0] rd_val;
   logic [2:0] dec_log_a;
   logic [2:0] dec_log_b;
   logic drdy;
   logic fresh_a;
   logic fresh_b;
   logic [CFPR_NCH-1:0] ch_sel;
   logic [CFPR_NCH-1:0] ch_fresh;

   cfpr_wb_slave u_bus (
      .ref_clk(ref_clk),
      .reset(reset),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o),
      .access_o(access)
   );

   // word addressed: low two bits ignored, index beyond the map answers zero
   assign idx = wb_adr_i[9:2];
   assign addr_ok = (idx == CFPR_IDX_PROF_A) || (idx == CFPR_IDX_PROF_B) ||
                    (idx == CFPR_IDX_MAP) || (idx == CFPR_IDX_STATUS);
   // registers are 8 bits wide, so only byte lane 0 carries a write
   assign wr_en = access && wb_we_i && wb_sel_i[0];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prof_a_q <= CFPR_RST_PROF_A;
      end else if (wr_en && idx == CFPR_IDX_PROF_A) begin
         prof_a_q <= wb_dat_i[7:0] & CFPR_PROF_MASK;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prof_b_q <= CFPR_RST_PROF_B;
      end else if (wr_en && idx == CFPR_IDX_PROF_B) begin
         prof_b_q <= wb_dat_i[7:0] & CFPR_PROF_MASK;
      end
   end

   // enable bits are stored as written; hardware relies on software matching them
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         map_q <= CFPR_RST_MAP;
      end else if (wr_en && idx == CFPR_IDX_MAP) begin
         map_q <= wb_dat_i[7:0] & CFPR_MAP_MASK;
      end
   end

   always_comb begin
      case (idx)
         CFPR_IDX_PROF_A: rd_val = prof_a_q;
         CFPR_IDX_PROF_B: rd_val = prof_b_q;
         CFPR_IDX_MAP: rd_val = map_q;
         CFPR_IDX_STATUS: rd_val = status_q;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
      end else if (access) begin
         rdata_q <= addr_ok ? {24'h000000, rd_val} : 32'h00000000;
      end
   end
   assign wb_dat_o = rdata_q;

   assign dec_log_a = cfpr_dec_log(prof_a_q[CFPR_DEC_LSB +: CFPR_DEC_W]);
   assign dec_log_b = cfpr_dec_log(prof_b_q[CFPR_DEC_LSB +: CFPR_DEC_W]);

   cfpr_pacer u_pace (
      .ref_clk(ref_clk),
      .reset(reset),
      .mod_tick_i(mod_tick_i),
      .dec_log_a(dec_log_a),
      .dec_log_b(dec_log_b),
      .phase_o(),
      .drdy_o(drdy),
      .fresh_a_o(fresh_a),
      .fresh_b_o(fresh_b)
   );

   // per-channel profile select, 0 is profile A
   assign ch_sel[0] = map_q[CFPR_MAP_CH0_SEL];
   assign ch_sel[1] = map_q[CFPR_MAP_CH1_SEL];
   assign ch_sel[2] = map_q[CFPR_MAP_CH2_SEL];
   assign ch_sel[3] = map_q[CFPR_MAP_CH3_SEL];

   always_comb begin
      for (int i = 0; i < CFPR_NCH; i++) begin
         ch_fresh[i] = ch_sel[i] ? fresh_b : fresh_a;
      end
   end

   // each channel sees the filter and decimation of its own profile
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ch_filter_o <= '0;
         ch_dec_o <= '0;
      end else begin
         for (int i = 0; i < CFPR_NCH; i++) begin
            ch_filter_o[i] <= ch_sel[i] ? prof_b_q[CFPR_FILT_BIT] : prof_a_q[CFPR_FILT_BIT];
            ch_dec_o[i*CFPR_DEC_W +: CFPR_DEC_W] <=
               ch_sel[i] ? prof_b_q[CFPR_DEC_LSB +: CFPR_DEC_W] :
                           prof_a_q[CFPR_DEC_LSB +: CFPR_DEC_W];
         end
      end
   end

   // output word latched on each data-ready; stale slots read zero with repeat set
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         out_data_o <= '0;
         out_repeat_o <= '0;
      end else if (drdy) begin
         for (int i = 0; i < CFPR_NCH; i++) begin
            out_data_o[i*CFPR_RES_W +: CFPR_RES_W] <=
               ch_fresh[i] ? raw_data_i[i*CFPR_RES_W +: CFPR_RES_W] : '0;
            out_repeat_o[i] <= ~ch_fresh[i];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         drdy_o <= 1'b0;
      end else begin
         drdy_o <= drdy;
      end
   end

   // status: live repeat flags in the low nibble, channel select map in the high
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         status_q <= 8'h00;
      end else begin
         status_q <= {ch_sel, out_repeat_o};
      end
   end
endmodule

// ---- cfpr_regs_assertions.sv ----
// cfpr_regs_chk: port-level assertions for the profile register bank
// assumes one clock ref_clk and async active-high reset; bound onto cfpr_regs
module cfpr_regs_chk
   import cfpr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic mod_tick_i,
   input wire logic [CFPR_NCH*CFPR_RES_W-1:0] out_data_o,
   input wire logic [CFPR_NCH-1:0] out_repeat_o,
   input wire logic [CFPR_NCH-1:0] ch_filter_o,
   input wire logic [CFPR_NCH*CFPR_DEC_W-1:0] ch_dec_o,
   input wire logic drdy_o
);
   logic [3:0] nz;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nz[i] = |out_data_o[24*i +: 24];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   // periods are at least 32 ticks, so eight quiet cycles is a safe floor
   chk_drdy_spacing: assert property (drdy_o |=> !drdy_o [*8])
      else $error("data-ready too close");
   chk_drdy_from_tick: assert property (drdy_o |-> $past(mod_tick_i))
      else $error("data-ready without tick");
   chk_repeat_zeroed: assert property ((out_repeat_o & nz) == 4'h0)
      else $error("repeated slot not zero");
   chk_out_on_drdy: assert property ($changed(out_data_o) || $changed(out_repeat_o) |-> drdy_o)
      else $error("output moved without data-ready");
   chk_cfg_by_write: assert property ($changed({ch_dec_o, ch_filter_o}) |->
      wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(reset) ||
      $past(reset, 2))
      else $error("channel config moved without write");
   cov_write: cover property (wb_ack_o && wb_we_i);
   cov_read: cover property (wb_ack_o && !wb_we_i);
   cov_repeat: cover property (drdy_o && out_repeat_o[0]);
endmodule

bind cfpr_regs cfpr_regs_chk u_chk (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_dat_o, .wb_ack_o, .mod_tick_i, .out_data_o, .out_repeat_o, .ch_filter_o, .ch_dec_o,
   .drdy_o);

// ---- cfpr_regs_tb_top.sv ----
// cfpr_regs_tb_top: wishbone register and output pacing tests
// assumes byte address = index*4 and a free-running 10-bit phase counter
module cfpr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mod_tick_i, drdy_o;
   logic [9:0] wb_adr_i;
   logic [3:0] wb_sel_i, out_repeat_o, ch_filter_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [95:0] raw_data_i, out_data_o;
   logic [11:0] ch_dec_o;
   logic [7:0] m [4] = '{8'h01, 8'h02, 8'h14, 8'h28};
   int fail_count = 0, num_checks = 0, cyc_n = 0, nd, nf, lg;
   cfpr_regs dut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .mod_tick_i, .raw_data_i, .out_data_o, .out_repeat_o,
      .ch_filter_o, .ch_dec_o, .drdy_o);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // about 17k cycles needed; the ceiling of 40000 leaves more than twice that
   always @(posedge ref_clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // entered right after a rising edge; waits for ack, then one idle cycle
   task automatic wb(input logic we, input logic [3:0] sel, input logic [9:0] a,
      input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= sel;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) @(posedge ref_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, 4'hF, a, 32'h0);
      chk($sformatf("reg %h", a), {24'h0, e}, rd);
   endtask
   initial begin
      reset <= 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, mod_tick_i} <= 4'h0;
      wb_sel_i <= 4'h0;
      wb_adr_i <= 10'h000;
      wb_dat_i <= 32'h0;
      raw_data_i <= 96'h123456_ABCDEF_654321_FEDCBA;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rchk(10'h004, 8'h0D);
      rchk(10'h008, 8'h0D);
      rchk(10'h00C, 8'h00);
      chk("filter", 32'hF, {28'h0, ch_filter_o});
      chk("dec", 32'hB6D, {20'h0, ch_dec_o});
      wb(1'b1, 4'hE, 10'h004, 32'h0);
      rchk(10'h004, 8'h0D);
      wb(1'b1, 4'hF, 10'h014, 32'hFF);
      rchk(10'h014, 8'h00);
      wb(1'b1, 4'hF, 10'h00C, 32'hFF);
      rchk(10'h00C, 8'h3F);
      wb(1'b1, 4'hF, 10'h004, 32'hF0);
      rchk(10'h004, 8'h00);
      wb(1'b1, 4'hF, 10'h008, 32'h0F);
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, 4'hF, 10'h00C, {24'h0, m[c]});
         rchk(10'h00C, m[c]);
         chk("filter", 32'(1 << c), {28'h0, ch_filter_o});
         chk("dec", 32'(7 << (3 * c)), {20'h0, ch_dec_o});
      end
      rchk(10'h040, 8'h80);
      mod_tick_i <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         for (int code = 0; code < 8; code++) begin
            wb(1'b1, 4'hF, 10'h004, p ? 32'h0 : 32'(code));
            wb(1'b1, 4'hF, 10'h008, p ? 32'(code) : 32'h0);
            wb(1'b1, 4'hF, 10'h00C, p ? 32'h01 : 32'h3E);
            lg = code > 5 ? 5 : code;
            nd = 0;
            nf = 0;
            // 1024 ticks is one full phase wrap, so counts do not depend on alignment
            repeat (1024) begin
               @(negedge ref_clk);
               if (drdy_o === 1'b1) begin
                  nd++;
                  nf += (out_repeat_o[0] === 1'b0);
                  chk("ch0 data", {8'h0, out_repeat_o[0] ? 24'h0 : 24'hFEDCBA},
                     {8'h0, out_data_o[23:0]});
                  chk("ch1-3 repeat", 32'h0, {29'h0, out_repeat_o[3:1]});
                  chk("ch1 data", 32'h654321, {8'h0, out_data_o[47:24]});
               end
            end
            @(posedge ref_clk);
            chk("drdy count", 32'd32, 32'(nd));
            chk("fresh count", 32'(32 >> lg), 32'(nf));
         end
      end
      final_report();
   end
endmodule
